// >>> src/cmdd_regs.vh
`ifndef CMDD_REGS_VH
`define CMDD_REGS_VH

// Register byte offsets on the Wishbone port
`define CMDD_REG_CHSEL 8'h00
`define CMDD_REG_CFG 8'h04
`define CMDD_REG_HEAD 8'h08
`define CMDD_REG_ACT 8'h0c
`define CMDD_REG_STAT 8'h10

// Message descriptor dword offsets
`define CMDD_DESC_BUF 32'h00000000
`define CMDD_DESC_DATA 32'h00000004
`define CMDD_DESC_NEXT 32'h00000008

// Buffer word fields
`define CMDD_BW_OWN 31
`define CMDD_BW_NP 30
`define CMDD_BW_EOM 29
`define CMDD_BLEN_W 14

// Channel configuration fields
`define CMDD_CFG_MSK_DUP 5
`define CMDD_CFG_MSK_IDLE 4
`define CMDD_CFG_MSK_MSG 3
`define CMDD_CFG_MSK_EOM 2
`define CMDD_CFG_MSK_INTERNAL_BUFFER_FAULT_EVENT 1
`define CMDD_CFG_PROTO_HI 14
`define CMDD_CFG_PROTO_LO 12
`define CMDD_PROTO_SS7 3'h1
`define CMDD_CFG_SELF 16
`define CMDD_CFG_RESET 32'h00000000

// Event codes
`define CMDD_EV_NONE 4'h0
`define CMDD_EV_DUP 4'h1
`define CMDD_EV_CHANGE_TO_ABORT_EVENT 4'h2
`define CMDD_EV_CHANGE_TO_IDLE_EVENT 4'h3
`define CMDD_EV_SHT 4'h4
`define CMDD_EV_LNG 4'h5
`define CMDD_EV_FCS 4'h6
`define CMDD_EV_ALIGN 4'h7
`define CMDD_EV_ABT 4'h8
`define CMDD_EV_EOM 4'h9
`define CMDD_EV_INTERNAL_BUFFER_FAULT_EVENT 4'ha
`define CMDD_EV_ONR 4'hb
`define CMDD_EV_MISS 4'hc

// Slot states
`define CMDD_SL_IDLE 2'h0
`define CMDD_SL_POLL 2'h1
`define CMDD_SL_PEND 2'h2
`define CMDD_SL_HELD 2'h3

// Poll interval
`define CMDD_POLL_NS 10000
`define CMDD_CLK_MHZ 200

`endif

// >>> src/cmdd_ctx_ram.v
`timescale 1ns/1ps
module cmdd_ctx_ram #(
	parameter AW = 3,
	parameter DW = 74
) (
	// Clock
	input wire clk,
	// Write port
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	// Read port
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// >>> src/cmdd_irq_filter.v
`timescale 1ns/1ps
`include "cmdd_regs.vh"
module cmdd_irq_filter (
	// Event
	input wire [3:0] code,
	input wire dirRx,
	// Channel configuration word
	input wire [31:0] cfg,
	// Result
	output reg pass
);
	wire mDup = cfg[`CMDD_CFG_MSK_DUP];
	wire mIdle = cfg[`CMDD_CFG_MSK_IDLE];
	wire mMsg = cfg[`CMDD_CFG_MSK_MSG];
	wire mEom = cfg[`CMDD_CFG_MSK_EOM];
	wire mBuff = cfg[`CMDD_CFG_MSK_INTERNAL_BUFFER_FAULT_EVENT];

	always @* begin
		pass = 1'b0;
		case (code)
			`CMDD_EV_DUP: pass = dirRx & ~mDup;
			`CMDD_EV_CHANGE_TO_ABORT_EVENT, `CMDD_EV_CHANGE_TO_IDLE_EVENT, `CMDD_EV_SHT: pass = dirRx & ~mIdle;
			// Check-type errors need both masks set to go quiet
			`CMDD_EV_LNG, `CMDD_EV_FCS, `CMDD_EV_ALIGN: pass = dirRx & ~(mMsg & mEom);
			`CMDD_EV_ABT: pass = dirRx & ~mMsg;
			`CMDD_EV_EOM: pass = ~mEom;
			`CMDD_EV_INTERNAL_BUFFER_FAULT_EVENT: pass = ~mBuff;
			`CMDD_EV_ONR, `CMDD_EV_MISS: pass = ~mBuff;
			default: pass = 1'b0;
		endcase
	end
endmodule

// >>> src/cmdd_engine.v
// Contract
// - Unmasked duplicate signalling message raises interrupt
// - Duplicate signalling message always discarded
// - Idle mask gates abort, idle, short events
// - Message mask gates long, check, align, abort; code needs the end mask too for long, check, align
// - Check errors masked only with end mask
// - End-of-message interrupt both directions unless masked
// - Buffer mask gates underflow and overflow interrupts
// - Buffer mask also gates not-ready interrupt
// - Descriptor is three dwords at 0,4,8
// - Check descriptor first, then write status
// - Status holds count, end flag, owner
// - Poll host-owned descriptor, then hand back
// - Never reuse buffer without new grant
// - Opening flag without buffer raises interrupt
// - Never access past data buffer end
// - Channels served independently, own lists
// - Transmit and receive keep separate lists
// - Linked descriptors chain buffers in order
// - Self-servicing mode shares one descriptor
// - Transmit owner bit 1 means device owns
// - No-poll bit chooses poll or wait
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "cmdd_regs.vh"
module cmdd_engine #(
	parameter CW = 2,
	parameter POLL_CYCLES = `CMDD_POLL_NS * `CMDD_CLK_MHZ / 1000
) (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Shared memory master
	output reg memReq,
	output reg memWe,
	output reg [31:0] memAddr,
	output reg [31:0] memWdata,
	input wire memAck,
	input wire [31:0] memRdata,
	// Buffer offer to data path
	output reg bufValid,
	output reg bufDir,
	output reg [CW-1:0] bufChan,
	output reg [31:0] bufAddr,
	output reg [`CMDD_BLEN_W-1:0] bufLen,
	input wire bufReady,
	// Buffer completion from data path
	input wire doneValid,
	input wire doneDir,
	input wire [CW-1:0] doneChan,
	input wire [`CMDD_BLEN_W-1:0] doneCount,
	input wire doneEom,
	input wire [15:0] doneSig,
	output reg doneAck,
	// Line events from data path
	input wire evValid,
	input wire evDir,
	input wire [CW-1:0] evChan,
	input wire [3:0] evCode,
	output reg evReady,
	// Receive opening flag
	input wire openValid,
	input wire [CW-1:0] openChan,
	// Interrupt event out
	output reg irqValid,
	output reg irqDir,
	output reg [CW-1:0] irqChan,
	output reg [3:0] irqCode
);
	localparam NCH = 1 << CW;
	localparam SW = CW + 1;
	localparam NSLOT = 1 << SW;
	localparam BW = `CMDD_BLEN_W;
	localparam RW = BW + 60;
	localparam [15:0] POLL_LAST = POLL_CYCLES - 1;

	localparam ST_SCAN = 4'h0;
	localparam ST_WAIT = 4'h1;
	localparam ST_CTX = 4'h2;
	localparam ST_RD0 = 4'h3;
	localparam ST_RD1 = 4'h4;
	localparam ST_RD2 = 4'h5;
	localparam ST_OFFER = 4'h6;
	localparam ST_WRST = 4'h7;

	integer i;

	reg [1:0] rstPipe_q;
	wire rstn = rstPipe_q[1];

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end

	reg [3:0] st_q;
	reg [SW-1:0] rr_q;
	reg [SW-1:0] cur_q;
	reg isDone_q;
	reg [BW-1:0] cnt_q;
	reg eomL_q;
	reg [15:0] sig_q;
	reg [29:0] fptr_q;
	reg [BW-1:0] blen_q;
	reg [15:0] pollCnt_q;
	reg pollTick_q;
	reg [1:0] slotSt_q [0:NSLOT-1];
	reg [29:0] headPtr_q [0:NSLOT-1];
	reg [NSLOT-1:0] headLd_q;
	reg [31:0] cfg_q [0:NCH-1];
	reg [15:0] lastSig_q [0:NCH-1];
	reg [NCH-1:0] lastSigV_q;
	reg [SW-1:0] chsel_q;
	reg engEvV_q;
	reg [3:0] engEvCode_q;
	reg [SW-1:0] engEvSlot_q;
	reg missV_q;
	reg [CW-1:0] missChan_q;

	reg ramWe;
	reg [RW-1:0] ramWdata;
	wire [RW-1:0] ramQ;

	cmdd_ctx_ram #(.AW(SW), .DW(RW)) uCtx (
		.clk(clk),
		.we(ramWe),
		.waddr(cur_q),
		.wdata(ramWdata),
		.raddr(cur_q),
		.rdata(ramQ)
	);

	// Context word: {buffer length, next pointer, current pointer}
	wire [BW-1:0] ctxLen = ramQ[RW-1:60];
	wire [29:0] ctxNext = ramQ[59:30];
	wire [29:0] ctxCur = ramQ[29:0];
	wire curRx = cur_q[0];
	wire [CW-1:0] curCh = cur_q[SW-1:1];
	wire [31:0] curCfg = cfg_q[curCh];
	wire curSs7 = curCfg[`CMDD_CFG_PROTO_HI:`CMDD_CFG_PROTO_LO] == `CMDD_PROTO_SS7;
	wire memDone = memReq & memAck;
	// Receive owner bit has inverted sense: 0 means device holds it
	wire devOwn = curRx ? ~memRdata[`CMDD_BW_OWN] : memRdata[`CMDD_BW_OWN];
	wire [BW-1:0] cntClamp = (cnt_q > ctxLen) ? ctxLen : cnt_q;
	wire isDup = curRx & curSs7 & eomL_q & lastSigV_q[curCh] & (sig_q == lastSig_q[curCh]);
	wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [SW-1:0] openSlot = {openChan, 1'b1};
	wire [SW-1:0] selfRx = {curCh, 1'b1};

	// Filter input priority: engine, missing buffer, external
	reg [3:0] fCode;
	reg [SW-1:0] fSlot;
	reg fValid;
	wire fPass;

	always @* begin
		fValid = 1'b0;
		fCode = `CMDD_EV_NONE;
		fSlot = {SW{1'b0}};
		if (engEvV_q) begin
			fValid = 1'b1;
			fCode = engEvCode_q;
			fSlot = engEvSlot_q;
		end else if (missV_q) begin
			fValid = 1'b1;
			fCode = `CMDD_EV_MISS;
			fSlot = {missChan_q, 1'b1};
		end else if (evValid & evReady) begin
			fValid = 1'b1;
			fCode = evCode;
			fSlot = {evChan, evDir};
		end
	end

	cmdd_irq_filter uFilt (
		.code(fCode),
		.dirRx(fSlot[0]),
		.cfg(cfg_q[fSlot[SW-1:1]]),
		.pass(fPass)
	);

	always @* begin
		ramWe = 1'b0;
		ramWdata = ramQ;
		case (st_q)
			ST_CTX: begin
				if (!isDone_q && headLd_q[cur_q]) begin
					ramWe = 1'b1;
					ramWdata = {ctxLen, ctxNext, headPtr_q[cur_q]};
				end
			end
			ST_RD2: begin
				if (memDone) begin
					ramWe = 1'b1;
					ramWdata = {blen_q, memRdata[31:2], fptr_q};
				end
			end
			// Follow the link to the next descriptor
			ST_WRST: begin
				if (memDone) begin
					ramWe = 1'b1;
					ramWdata = {ctxLen, ctxNext, ctxNext};
				end
			end
			default: ramWe = 1'b0;
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pollCnt_q <= 16'h0000;
			pollTick_q <= 1'b0;
		end else begin
			pollTick_q <= (pollCnt_q == POLL_LAST);
			pollCnt_q <= (pollCnt_q == POLL_LAST) ? 16'h0000 : pollCnt_q + 16'h0001;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_SCAN;
			rr_q <= {SW{1'b0}};
			cur_q <= {SW{1'b0}};
			isDone_q <= 1'b0;
			cnt_q <= {BW{1'b0}};
			eomL_q <= 1'b0;
			sig_q <= 16'h0000;
			fptr_q <= 30'h00000000;
			blen_q <= {BW{1'b0}};
			headLd_q <= {NSLOT{1'b0}};
			lastSigV_q <= {NCH{1'b0}};
			chsel_q <= {SW{1'b0}};
			engEvV_q <= 1'b0;
			engEvCode_q <= `CMDD_EV_NONE;
			engEvSlot_q <= {SW{1'b0}};
			missV_q <= 1'b0;
			missChan_q <= {CW{1'b0}};
			for (i = 0; i < NSLOT; i = i + 1) begin
				slotSt_q[i] <= `CMDD_SL_IDLE;
				headPtr_q[i] <= 30'h00000000;
			end
			for (i = 0; i < NCH; i = i + 1) begin
				cfg_q[i] <= `CMDD_CFG_RESET;
				lastSig_q[i] <= 16'h0000;
			end
			memReq <= 1'b0;
			memWe <= 1'b0;
			memAddr <= 32'h00000000;
			memWdata <= 32'h00000000;
			bufValid <= 1'b0;
			bufDir <= 1'b0;
			bufChan <= {CW{1'b0}};
			bufAddr <= 32'h00000000;
			bufLen <= {BW{1'b0}};
			doneAck <= 1'b0;
			evReady <= 1'b0;
			irqValid <= 1'b0;
			irqDir <= 1'b0;
			irqChan <= {CW{1'b0}};
			irqCode <= `CMDD_EV_NONE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			doneAck <= 1'b0;
			irqValid <= fValid & fPass;
			irqDir <= fSlot[0];
			irqChan <= fSlot[SW-1:1];
			irqCode <= fCode;
			if (engEvV_q) begin
				engEvV_q <= 1'b0;
			end else if (missV_q) begin
				missV_q <= 1'b0;
			end
			// Poll tick wakes every host-owned slot that may poll
			if (pollTick_q) begin
				for (i = 0; i < NSLOT; i = i + 1) begin
					if (slotSt_q[i] == `CMDD_SL_POLL) begin
						slotSt_q[i] <= `CMDD_SL_PEND;
					end
				end
			end
			// Opening flag while no receive buffer is held
			if (openValid && slotSt_q[openSlot] != `CMDD_SL_HELD) begin
				missV_q <= 1'b1;
				missChan_q <= openChan;
			end
			if (memDone) begin
				memReq <= 1'b0;
			end
			case (st_q)
				ST_SCAN: begin
					if (doneValid && !doneAck) begin
						doneAck <= 1'b1;
						cur_q <= {doneChan, doneDir};
						isDone_q <= 1'b1;
						cnt_q <= doneCount;
						eomL_q <= doneEom;
						sig_q <= doneSig;
						st_q <= ST_WAIT;
					end else begin
						// One slot looked at per cycle, so none can starve another
						rr_q <= rr_q + 1'b1;
						if (slotSt_q[rr_q] == `CMDD_SL_PEND) begin
							cur_q <= rr_q;
							isDone_q <= 1'b0;
							st_q <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					st_q <= ST_CTX;
				end
				ST_CTX: begin
					if (isDone_q) begin
						if (isDup) begin
							// Keep the same buffer; the duplicate is dropped
							engEvV_q <= 1'b1;
							engEvCode_q <= `CMDD_EV_DUP;
							engEvSlot_q <= cur_q;
							slotSt_q[cur_q] <= `CMDD_SL_PEND;
							st_q <= ST_SCAN;
						end else begin
							if (curRx && curSs7 && eomL_q) begin
								lastSig_q[curCh] <= sig_q;
								lastSigV_q[curCh] <= 1'b1;
							end
							memReq <= 1'b1;
							memWe <= 1'b1;
							memAddr <= {ctxCur, 2'b00} + `CMDD_DESC_BUF;
							// Owner flips back to the host in either sense
							memWdata <= {curRx, 1'b0, eomL_q, {(29-BW){1'b0}}, cntClamp};
							st_q <= ST_WRST;
						end
					end else begin
						fptr_q <= headLd_q[cur_q] ? headPtr_q[cur_q] : ctxCur;
						headLd_q[cur_q] <= 1'b0;
						memReq <= 1'b1;
						memWe <= 1'b0;
						memAddr <= {(headLd_q[cur_q] ? headPtr_q[cur_q] : ctxCur), 2'b00}
							+ `CMDD_DESC_BUF;
						st_q <= ST_RD0;
					end
				end
				ST_RD0: begin
					if (memDone) begin
						if (!devOwn) begin
							slotSt_q[cur_q] <= memRdata[`CMDD_BW_NP] ?
								`CMDD_SL_IDLE : `CMDD_SL_POLL;
							engEvV_q <= 1'b1;
							engEvCode_q <= `CMDD_EV_ONR;
							engEvSlot_q <= cur_q;
							st_q <= ST_SCAN;
						end else begin
							blen_q <= memRdata[BW-1:0];
							memReq <= 1'b1;
							memAddr <= {fptr_q, 2'b00} + `CMDD_DESC_DATA;
							st_q <= ST_RD1;
						end
					end
				end
				ST_RD1: begin
					if (memDone) begin
						bufAddr <= memRdata;
						memReq <= 1'b1;
						memAddr <= {fptr_q, 2'b00} + `CMDD_DESC_NEXT;
						st_q <= ST_RD2;
					end
				end
				ST_RD2: begin
					if (memDone) begin
						bufValid <= 1'b1;
						bufDir <= curRx;
						bufChan <= curCh;
						bufLen <= blen_q;
						st_q <= ST_OFFER;
					end
				end
				ST_OFFER: begin
					if (bufReady) begin
						bufValid <= 1'b0;
						slotSt_q[cur_q] <= `CMDD_SL_HELD;
						st_q <= ST_SCAN;
					end
				end
				ST_WRST: begin
					if (memDone) begin
						slotSt_q[cur_q] <= `CMDD_SL_PEND;
						if (eomL_q) begin
							engEvV_q <= 1'b1;
							engEvCode_q <= `CMDD_EV_EOM;
							engEvSlot_q <= cur_q;
						end
						// Loopback: the finished transmit buffer now belongs to receive
						if (!curRx && curCfg[`CMDD_CFG_SELF]
							&& slotSt_q[selfRx] != `CMDD_SL_HELD) begin
							slotSt_q[selfRx] <= `CMDD_SL_PEND;
						end
						st_q <= ST_SCAN;
					end
				end
				default: st_q <= ST_SCAN;
			endcase
			evReady <= ~(engEvV_q | missV_q) & ~(openValid | (st_q == ST_RD0) | (st_q == ST_WRST));
			// Register port; host activation lands after the engine so it wins
			wb_ack_o <= wbReq;
			if (wbReq) begin
				wb_dat_o <= 32'h00000000;
				case (wb_adr_i)
					`CMDD_REG_CHSEL: begin
						if (wb_we_i && wb_sel_i[0]) begin
							chsel_q <= wb_dat_i[SW-1:0];
						end
						wb_dat_o <= {{(32-SW){1'b0}}, chsel_q};
					end
					`CMDD_REG_CFG: begin
						for (i = 0; i < 4; i = i + 1) begin
							if (wb_we_i && wb_sel_i[i]) begin
								cfg_q[chsel_q[SW-1:1]][i*8 +: 8] <= wb_dat_i[i*8 +: 8];
							end
						end
						wb_dat_o <= cfg_q[chsel_q[SW-1:1]];
					end
					`CMDD_REG_HEAD: begin
						if (wb_we_i && wb_sel_i == 4'hf) begin
							headPtr_q[chsel_q] <= wb_dat_i[31:2];
						end
						wb_dat_o <= {headPtr_q[chsel_q], 2'b00};
					end
					`CMDD_REG_ACT: begin
						for (i = 0; i < 2; i = i + 1) begin
							if (wb_we_i && wb_sel_i[0] && wb_dat_i[i]) begin
								headLd_q[{chsel_q[SW-1:1], i[0]}] <= 1'b1;
								slotSt_q[{chsel_q[SW-1:1], i[0]}] <= `CMDD_SL_PEND;
								// Self-servicing: receive starts on the transmit list
								if (i == 1 && cfg_q[chsel_q[SW-1:1]][`CMDD_CFG_SELF]) begin
									headPtr_q[{chsel_q[SW-1:1], 1'b1}] <=
										headPtr_q[{chsel_q[SW-1:1], 1'b0}];
								end
							end
						end
					end
					`CMDD_REG_STAT: begin
						wb_dat_o <= {{23{1'b0}}, (st_q != ST_SCAN), 4'h0,
							slotSt_q[{chsel_q[SW-1:1], 1'b1}],
							slotSt_q[{chsel_q[SW-1:1], 1'b0}]};
					end
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// >>> tb/cmdd_monitor.sv
`timescale 1ns/1ps
module cmdd_monitor (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Register bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// Memory master
	input wire memReq,
	input wire memWe,
	input wire [31:0] memAddr,
	input wire [31:0] memWdata,
	input wire memAck,
	// Data path
	input wire bufValid,
	input wire bufReady,
	input wire [31:0] bufAddr,
	input wire doneValid,
	input wire doneDir,
	input wire doneAck
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_wbReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_txDone; doneAck && !doneDir; endsequence
	sequence s_statWr; memReq && memWe && memAck; endsequence
	property p_wbAck; s_wbReq |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_memHold; memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe); endproperty
	property p_memAlign; memReq |-> memAddr[1:0] == 2'h0; endproperty
	property p_status; memReq && memWe |-> !memWdata[30] && memWdata[28:14] == 15'h0; endproperty
	property p_bufHold; bufValid && !bufReady |=> bufValid && $stable(bufAddr); endproperty
	property p_doneAck; doneAck |-> $past(doneValid) ##1 !doneAck; endproperty
	// A lost status write would strand the buffer with the device
	property p_statAfter; s_txDone |-> ##[1:300] s_statWr; endproperty
	property p_memWrOnce; s_statWr |=> !memReq; endproperty
	a_wbAck: assert property (p_wbAck) else $error("bus ack");
	a_memHold: assert property (p_memHold) else $error("mem hold");
	a_memAlign: assert property (p_memAlign) else $error("mem align");
	a_status: assert property (p_status) else $error("status word");
	a_bufHold: assert property (p_bufHold) else $error("buf hold");
	a_doneAck: assert property (p_doneAck) else $error("done ack");
	a_statAfter: assert property (p_statAfter) else $error("no status");
	a_memWrOnce: assert property (p_memWrOnce) else $error("double write");
endmodule
bind cmdd_engine cmdd_monitor mon (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.memReq, .memWe, .memAddr, .memWdata, .memAck, .bufValid, .bufReady, .bufAddr,
	.doneValid, .doneDir, .doneAck);

// >>> tb/cmdd_host_mem.sv
`timescale 1ns/1ps
module cmdd_host_mem (
	// Clock
	input wire clk,
	// Memory port
	input wire memReq,
	input wire memWe,
	input wire [31:0] memAddr,
	input wire [31:0] memWdata,
	output reg memAck = 1'b0,
	output reg [31:0] memRdata = 32'h0
);
	reg [31:0] mem [0:255] = '{default: 32'h0};
	integer rd [0:255] = '{default: 0};
	reg [1:0] dly = 2'h0;
	// Read data toggles outside ack so a stale value never looks valid
	always @(posedge clk) begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (memReq && !memAck) begin
			if (dly != 2'h0) begin
				dly <= dly - 2'h1;
			end else begin
				memAck <= 1'b1;
				dly <= memAddr[3:2];
				if (memWe) begin
					mem[memAddr[9:2]] <= memWdata;
				end else begin
					memRdata <= mem[memAddr[9:2]];
					rd[memAddr[9:2]] <= rd[memAddr[9:2]] + 1;
				end
			end
		end
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	reg [7:0] wb_adr_i = 8'h0;
	reg [3:0] wb_sel_i = 4'h0, evCode = 4'h0;
	reg [31:0] wb_dat_i = 32'h0, q, cfg;
	reg bufReady = 1'b0, doneValid = 1'b0, doneDir = 1'b0, doneEom = 1'b0;
	reg evValid = 1'b0, evDir = 1'b1, openValid = 1'b0;
	reg [1:0] doneChan = 2'h0, evChan = 2'h0, openChan = 2'h0;
	reg [13:0] doneCount = 14'h0;
	reg [15:0] doneSig = 16'h0;
	wire [31:0] wb_dat_o, memAddr, memWdata, memRdata, bufAddr;
	wire wb_ack_o, memReq, memWe, memAck, bufValid, bufDir, doneAck, evReady, irqValid, irqDir;
	wire [1:0] bufChan, irqChan;
	wire [13:0] bufLen;
	wire [3:0] irqCode;
	integer err_count = 0, tests_run = 0, cyc = 0, seed = 32'hf621, i;
	reg [2:0] lastIrq = 3'h0;
	integer expI [0:15] = '{default: 0};
	integer seenI [0:15] = '{default: 0};

	cmdd_engine #(.CW(2), .POLL_CYCLES(16)) dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .memReq, .memWe, .memAddr,
		.memWdata, .memAck, .memRdata, .bufValid, .bufDir, .bufChan, .bufAddr, .bufLen,
		.bufReady, .doneValid, .doneDir, .doneChan, .doneCount, .doneEom, .doneSig, .doneAck,
		.evValid, .evDir, .evChan, .evCode, .evReady, .openValid, .openChan, .irqValid,
		.irqDir, .irqChan, .irqCode);
	cmdd_host_mem host (.clk, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata);

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (irqValid === 1'b1) begin
			seenI[irqCode] = seenI[irqCode] + 1;
			lastIrq = {irqDir, irqChan};
		end
		if (cyc == 20000) begin
			err_count = err_count + 1;
			give_verdict;
		end
	end

	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	task chk(input [31:0] seen, input [31:0] exp, input string what);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task wbx(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= d;
			wb_sel_i <= 4'hf;
			@(posedge clk);
			while (wb_ack_o !== 1'b1) @(posedge clk);
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask

	task cfgCh(input [2:0] s, input [31:0] cf, input [31:0] head, input [1:0] act);
		begin
			wbx(8'h00, 1'b1, {29'h0, s});
			wbx(8'h04, 1'b1, cf);
			wbx(8'h08, 1'b1, head);
			wbx(8'h0c, 1'b1, {30'h0, act});
		end
	endtask

	task serve(input d, input [1:0] c, input [31:0] ba, input [13:0] bl, input [13:0] cnt,
		input eo, input [15:0] sg);
		begin
			while (bufValid !== 1'b1) @(posedge clk);
			chk(bufAddr, ba, "bufAddr");
			chk({bufDir, bufChan, bufLen}, {d, c, bl}, "bufOffer");
			bufReady <= 1'b1;
			@(posedge clk);
			bufReady <= 1'b0;
			doneValid <= 1'b1;
			doneDir <= d;
			doneChan <= c;
			doneCount <= cnt;
			doneEom <= eo;
			doneSig <= sg;
			@(posedge clk);
			while (doneAck !== 1'b1) @(posedge clk);
			doneValid <= 1'b0;
		end
	endtask

	task opn(input [1:0] c);
		begin
			@(posedge clk);
			openValid <= 1'b1;
			openChan <= c;
			@(posedge clk);
			openValid <= 1'b0;
			repeat (10) @(posedge clk);
		end
	endtask

	// Expected filter outcome; long and check errors need both masks to hide
	function integer pass(input [3:0] c, input [31:0] m);
		case (c)
			4'h1: pass = !m[5];
			4'h2, 4'h3, 4'h4: pass = !m[4];
			4'h5, 4'h6, 4'h7: pass = !(m[3] && m[2]);
			4'h8: pass = !m[3];
			4'h9: pass = !m[2];
			default: pass = !m[1];
		endcase
	endfunction

	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		wbx(8'h10, 1'b0, 32'h0);
		chk(q, 32'h0, "stat");
		wbx(8'h14, 1'b1, 32'h5a);
		wbx(8'h14, 1'b0, 32'h0);
		chk(q, 32'h0, "unmapped");
		// Channel 0 transmit, second descriptor host-owned without polling
		host.mem[16] = 32'ha000_0008;
		host.mem[17] = 32'h100;
		host.mem[18] = 32'h50;
		host.mem[20] = 32'h4000_0000;
		host.mem[66] = 32'h5a5a_0001;
		cfgCh(3'h0, 32'h0, 32'h40, 2'h1);
		serve(1'b0, 2'h0, 32'h100, 14'h8, 14'h8, 1'b1, 16'h0);
		expI[9] = expI[9] + 1;
		expI[11] = expI[11] + 1;
		repeat (200) @(posedge clk);
		chk(host.mem[16], 32'h2000_0008, "txStatus");
		chk(host.rd[20], 1, "noPoll");
		chk(host.mem[66], 32'h5a5a_0001, "pastEnd");
		// Channel 2 polls until granted, buffer faults masked
		host.mem[24] = 32'h4;
		host.mem[25] = 32'h140;
		host.mem[26] = 32'h60;
		cfgCh(3'h4, 32'h2, 32'h60, 2'h1);
		repeat (100) @(posedge clk);
		chk(host.rd[24] > 2, 1, "polled");
		host.mem[24] = 32'h8000_0004;
		serve(1'b0, 2'h2, 32'h140, 14'h4, 14'h4, 1'b0, 16'h0);
		repeat (100) @(posedge clk);
		chk(host.mem[24], 32'h4, "txStatus2");
		chk(bufValid, 0, "noReuse");
		// Channel 1 receive ring, signalling protocol, end interrupt masked
		host.mem[32] = 32'h10;
		host.mem[33] = 32'h200;
		host.mem[34] = 32'h90;
		host.mem[36] = 32'h10;
		host.mem[37] = 32'h300;
		host.mem[38] = 32'h80;
		cfgCh(3'h3, 32'h1004, 32'h80, 2'h2);
		serve(1'b1, 2'h1, 32'h200, 14'h10, 14'h5, 1'b1, 16'h1234);
		serve(1'b1, 2'h1, 32'h300, 14'h10, 14'h5, 1'b1, 16'h1234);
		expI[1] = expI[1] + 1;
		while (bufValid !== 1'b1) @(posedge clk);
		chk(bufAddr, 32'h300, "refetch");
		chk(host.mem[32], 32'ha000_0005, "rxStatus");
		chk(host.mem[36], 32'h10, "dupKept");
		// Opening flag on channel 3 with no buffer, then masked
		cfgCh(3'h7, 32'h0, 32'h0, 2'h0);
		opn(2'h3);
		expI[12] = expI[12] + 1;
		chk(lastIrq, {1'b1, 2'h3}, "irqSource");
		wbx(8'h04, 1'b1, 32'h2);
		opn(2'h3);
		for (i = 0; i < 36; i = i + 1) begin
			cfg = ($random(seed) & 32'h3e) | 32'h1000;
			wbx(8'h04, 1'b1, cfg);
			evValid <= 1'b1;
			evChan <= 2'h3;
			evCode <= 4'((i % 12) + 1);
			@(posedge clk);
			while (evReady !== 1'b1) @(posedge clk);
			evValid <= 1'b0;
			expI[(i % 12) + 1] = expI[(i % 12) + 1] + pass(4'((i % 12) + 1), cfg);
			repeat (4) @(posedge clk);
		end
		repeat (20) @(posedge clk);
		for (i = 1; i < 13; i = i + 1) chk(seenI[i], expI[i], "irqCount");
		give_verdict;
	end
endmodule
